// *** csr_pkg.sv ***
package csr_pkg;
    // --------------------------------------------------------------
    // Register file addresses
    // --------------------------------------------------------------
    localparam logic [4:0] CSR_ADDR_INDIRECT = 5'h00;
    localparam logic [4:0] CSR_ADDR_PC_LOW   = 5'h02;
    localparam logic [4:0] CSR_ADDR_STATUS   = 5'h03;
    localparam logic [4:0] CSR_ADDR_POINTER  = 5'h04;
    localparam logic [4:0] CSR_ADDR_PORT_A   = 5'h05;
    localparam logic [4:0] CSR_ADDR_PORT_B   = 5'h06;

    // --------------------------------------------------------------
    // Status bit positions
    // --------------------------------------------------------------
    localparam int CSR_ST_CARRY  = 0;
    localparam int CSR_ST_NIBBLE = 1;
    localparam int CSR_ST_NULL   = 2;
    localparam int CSR_ST_PDOWN  = 3;
    localparam int CSR_ST_WDOG   = 4;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0] CSR_STATUS_RST = 8'h18;
    localparam logic [5:0] CSR_OPTION_RST = 6'h3F;
    localparam logic [7:0] CSR_DIR_RST    = 8'hFF;
    localparam logic [8:0] CSR_PC_RST     = 9'h1FF;
    localparam logic [8:0] CSR_STACK_RST  = 9'h000;
    localparam logic [4:0] CSR_PTR_RST    = 5'h00;
    localparam logic [7:0] CSR_LATCH_RST  = 8'h00;

    // --------------------------------------------------------------
    // Program counter operations
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        CSR_PC_STEP  = 3'b000,
        CSR_PC_JUMP  = 3'b001,
        CSR_PC_CALL  = 3'b010,
        CSR_PC_RET   = 3'b011,
        CSR_PC_HOLD  = 3'b100
    } csr_pc_op_e;

    // Flag update request from the execution unit
    typedef struct packed {
        logic       upd_null;
        logic       upd_nibble;
        logic       upd_carry;
        logic       null_val;
        logic       nibble_val;
        logic       carry_val;
    } csr_flags_s;

    // Timer configuration as decoded for the timer block
    typedef struct packed {
        logic       ext_source;
        logic       falling_edge;
        logic       bypass;
        logic [8:0] divide_ratio;
    } csr_timer_cfg_s;
endpackage : csr_pkg

// *** csr_core.sv ***
// Notes on behaviour
// - Flag-updating op overrides status write of flags
// - Watchdog and power-down bits ignore writes
// - Power-down set at reset, cleared by halt
// - Null flag set on zero result
// - Nibble carry: add carry, subtract no-borrow
// - Carry bit: add, subtract, rotate semantics
// - Six-bit write-only option, reset all ones
// - Option bit 5 selects external source
// - Option bit 4 selects falling edge
// - Option bit 3 bypasses prescaler
// - Rate code gives 1:2 up to 1:256
// - Program counter advances on each step op without a low-byte write
// - Jump loads all nine bits
// - Call or low-byte write clears bit 8
// - Call pushes two-level stack
// - Return pops stack and loads literal
// - Reset sets every counter bit
// - Indirect address uses pointer target
// - Pointer at indirect: read zero, write none
// - Port reads return pin levels
// - Port A four bits, upper read zero
// - Direction write-only, reset ones, one floats
// - Output latch holds until next write
module csr_core
    import csr_pkg::*;
(
    input  wire logic                  CLK_SYS_I,        // Instruction-cycle clock
    input  wire logic                  RST_N_I,          // Async reset, active low
    input  wire csr_pkg::csr_pc_op_e   PC_OP_I,          // Program counter operation
    input  wire logic [8:0]            PC_LOAD_I,        // Jump target
    input  wire logic [7:0]            LITERAL_I,        // Return literal
    input  wire logic [4:0]            RD_ADDR_I,        // Operand read address
    input  wire logic [4:0]            WR_ADDR_I,        // Destination address
    input  wire logic                  WR_EN_I,          // Destination write strobe
    input  wire logic [7:0]            WR_DATA_I,        // Destination data
    input  wire csr_pkg::csr_flags_s   FLAGS_I,          // Flag updates
    input  wire logic                  HALT_I,           // Low-power halt executed
    input  wire logic                  OPTION_LOAD_I,    // Option-load instruction
    input  wire logic                  DIR_LOAD_A_I,     // Direction load, port A
    input  wire logic                  DIR_LOAD_B_I,     // Direction load, port B
    input  wire logic [7:0]            ACC_I,            // Accumulator value
    input  wire logic [7:0]            EXT_RD_DATA_I,    // Data from other registers
    input  wire logic [3:0]            PORT_A_PIN_I,     // Port A pin levels
    input  wire logic [7:0]            PORT_B_PIN_I,     // Port B pin levels
    output logic [8:0]                 PC_O,             // Program counter
    output logic [7:0]                 RD_DATA_O,        // Operand read data
    output logic [4:0]                 EFF_RD_ADDR_O,    // Resolved read address
    output logic [4:0]                 EFF_WR_ADDR_O,    // Resolved write address
    output logic                       EFF_WR_EN_O,      // Resolved write strobe
    output logic                       ACC_LOAD_O,       // Accumulator takes literal
    output logic [7:0]                 ACC_DATA_O,       // Literal for accumulator
    output csr_pkg::csr_timer_cfg_s    TIMER_CFG_O,      // Decoded timer settings
    output logic [3:0]                 PORT_A_OUT_O,     // Port A latch
    output logic [3:0]                 PORT_A_OE_O,      // Port A drive enable
    output logic [7:0]                 PORT_B_OUT_O,     // Port B latch
    output logic [7:0]                 PORT_B_OE_O,      // Port B drive enable
    output logic [7:0]                 STATUS_O          // Status register
);
    import csr_pkg::*;

    logic [8:0] pc_q;
    logic [8:0] stack1_q;
    logic [8:0] stack2_q;
    logic [7:0] status_q;
    logic [5:0] option_q;
    logic [4:0] pointer_q;
    logic [3:0] latch_a_q;
    logic [7:0] latch_b_q;
    logic [3:0] dir_a_q;
    logic [7:0] dir_b_q;
    logic [3:0] pin_a_s1_q;
    logic [3:0] pin_a_q;
    logic [7:0] pin_b_s1_q;
    logic [7:0] pin_b_q;
    logic [4:0] rd_eff;
    logic [4:0] wr_eff;
    logic       wr_ok;
    logic [7:0] rd_d;

    // --------------------------------------------------------------
    // Address resolution
    // --------------------------------------------------------------
    // indirect redirection
    assign rd_eff = (RD_ADDR_I == CSR_ADDR_INDIRECT) ? pointer_q : RD_ADDR_I;
    assign wr_eff = (WR_ADDR_I == CSR_ADDR_INDIRECT) ? pointer_q : WR_ADDR_I;
    assign wr_ok  = WR_EN_I && (wr_eff != CSR_ADDR_INDIRECT);

    // --------------------------------------------------------------
    // Read multiplexer
    // --------------------------------------------------------------
    always_comb begin
        unique case (rd_eff)
            CSR_ADDR_INDIRECT: rd_d = 8'h00;
            CSR_ADDR_PC_LOW:   rd_d = pc_q[7:0];
            CSR_ADDR_STATUS:   rd_d = status_q;
            CSR_ADDR_POINTER:  rd_d = {3'h0, pointer_q};
            CSR_ADDR_PORT_A:   rd_d = {4'h0, pin_a_q};
            CSR_ADDR_PORT_B:   rd_d = pin_b_q;
            default:           rd_d = EXT_RD_DATA_I;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RD_DATA_O     <= 8'h00;
            EFF_RD_ADDR_O <= 5'h00;
            EFF_WR_ADDR_O <= 5'h00;
            EFF_WR_EN_O   <= 1'b0;
        end else begin
            RD_DATA_O     <= rd_d;
            EFF_RD_ADDR_O <= rd_eff;
            EFF_WR_ADDR_O <= wr_eff;
            EFF_WR_EN_O   <= wr_ok;
        end
    end

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_a_s1_q <= 4'h0;
            pin_a_q    <= 4'h0;
            pin_b_s1_q <= 8'h00;
            pin_b_q    <= 8'h00;
        end else begin
            pin_a_s1_q <= PORT_A_PIN_I;
            pin_a_q    <= pin_a_s1_q;
            pin_b_s1_q <= PORT_B_PIN_I;
            pin_b_q    <= pin_b_s1_q;
        end
    end

    // --------------------------------------------------------------
    // Program counter and stack
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pc_q     <= CSR_PC_RST;
            stack1_q <= CSR_STACK_RST;
            stack2_q <= CSR_STACK_RST;
        end else begin
            unique case (PC_OP_I)
                CSR_PC_JUMP: pc_q <= PC_LOAD_I;
                CSR_PC_CALL: begin
                    pc_q     <= {1'b0, PC_LOAD_I[7:0]};
                    stack2_q <= stack1_q;
                    stack1_q <= pc_q + 9'h001;
                end
                CSR_PC_RET: begin
                    pc_q     <= stack1_q;
                    stack1_q <= stack2_q;
                end
                CSR_PC_HOLD: pc_q <= pc_q;
                default: begin
                    if (wr_ok && wr_eff == CSR_ADDR_PC_LOW) begin
                        pc_q <= {1'b0, WR_DATA_I};
                    end else begin
                        pc_q <= pc_q + 9'h001;
                    end
                end
            endcase
        end
    end

    assign PC_O = pc_q;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ACC_LOAD_O <= 1'b0;
            ACC_DATA_O <= 8'h00;
        end else begin
            ACC_LOAD_O <= (PC_OP_I == CSR_PC_RET);
            ACC_DATA_O <= LITERAL_I;
        end
    end

    // --------------------------------------------------------------
    // Status register
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            status_q <= CSR_STATUS_RST;
        end else begin
            if (wr_ok && wr_eff == CSR_ADDR_STATUS) begin
                status_q[7:5]          <= WR_DATA_I[7:5];
                status_q[CSR_ST_NULL]   <= WR_DATA_I[CSR_ST_NULL];
                status_q[CSR_ST_NIBBLE] <= WR_DATA_I[CSR_ST_NIBBLE];
                status_q[CSR_ST_CARRY]  <= WR_DATA_I[CSR_ST_CARRY];
            end
            if (FLAGS_I.upd_null) begin
                status_q[CSR_ST_NULL] <= FLAGS_I.null_val;
            end
            if (FLAGS_I.upd_nibble) begin
                status_q[CSR_ST_NIBBLE] <= FLAGS_I.nibble_val;
            end
            if (FLAGS_I.upd_carry) begin
                status_q[CSR_ST_CARRY] <= FLAGS_I.carry_val;
            end
            status_q[CSR_ST_WDOG] <= 1'b1;
            if (HALT_I) begin
                status_q[CSR_ST_PDOWN] <= 1'b0;
            end
        end
    end

    assign STATUS_O = status_q;

    // --------------------------------------------------------------
    // Pointer, option and timer decode
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pointer_q <= CSR_PTR_RST;
        end else if (wr_ok && wr_eff == CSR_ADDR_POINTER) begin
            pointer_q <= WR_DATA_I[4:0];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            option_q <= CSR_OPTION_RST;
        end else if (OPTION_LOAD_I) begin
            option_q <= ACC_I[5:0];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TIMER_CFG_O <= '0;
        end else begin
            TIMER_CFG_O.ext_source   <= option_q[5];
            TIMER_CFG_O.falling_edge <= option_q[4];
            TIMER_CFG_O.bypass       <= option_q[3];
            TIMER_CFG_O.divide_ratio <= option_q[3] ? 9'h001
                                      : (9'h002 << option_q[2:0]);
        end
    end

    // --------------------------------------------------------------
    // Port latches and direction
    // --------------------------------------------------------------
    // latch holds until written
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            latch_a_q <= CSR_LATCH_RST[3:0];
            latch_b_q <= CSR_LATCH_RST;
        end else begin
            if (wr_ok && wr_eff == CSR_ADDR_PORT_A) begin
                latch_a_q <= WR_DATA_I[3:0];
            end
            if (wr_ok && wr_eff == CSR_ADDR_PORT_B) begin
                latch_b_q <= WR_DATA_I;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            dir_a_q <= CSR_DIR_RST[3:0];
            dir_b_q <= CSR_DIR_RST;
        end else begin
            if (DIR_LOAD_A_I) begin
                dir_a_q <= ACC_I[3:0];
            end
            if (DIR_LOAD_B_I) begin
                dir_b_q <= ACC_I;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PORT_A_OUT_O <= 4'h0;
            PORT_A_OE_O  <= 4'h0;
            PORT_B_OUT_O <= 8'h00;
            PORT_B_OE_O  <= 8'h00;
        end else begin
            PORT_A_OUT_O <= latch_a_q;
            PORT_A_OE_O  <= ~dir_a_q;
            PORT_B_OUT_O <= latch_b_q;
            PORT_B_OE_O  <= ~dir_b_q;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    wdog_always_one_a: assert property (status_q[CSR_ST_WDOG])
        else $error("watchdog flag not one");
    halt_clears_pdown_a: assert property (HALT_I |=> !status_q[CSR_ST_PDOWN])
        else $error("power-down not cleared");
    flag_wins_a: assert property (FLAGS_I.upd_null |=>
        status_q[CSR_ST_NULL] == $past(FLAGS_I.null_val))
        else $error("null flag not from op");
    jump_load_a: assert property (PC_OP_I == CSR_PC_JUMP |=> pc_q == $past(PC_LOAD_I))
        else $error("jump target wrong");
    call_push_a: assert property (PC_OP_I == CSR_PC_CALL |=>
        pc_q[8] == 1'b0 && stack1_q == $past(pc_q) + 9'h001)
        else $error("call push wrong");
    call_ret_a: assert property (PC_OP_I == CSR_PC_CALL ##1 PC_OP_I == CSR_PC_RET |=>
        pc_q == $past(pc_q, 2) + 9'h001)
        else $error("return address wrong");
    ret_pop_a: assert property (PC_OP_I == CSR_PC_RET |=>
        pc_q == $past(stack1_q) && stack1_q == $past(stack2_q))
        else $error("return pop wrong");
    acc_literal_a: assert property (PC_OP_I == CSR_PC_RET |=>
        ACC_LOAD_O && ACC_DATA_O == $past(LITERAL_I))
        else $error("return literal wrong");
    step_adv_a: assert property (
        PC_OP_I == CSR_PC_STEP && !(wr_ok && wr_eff == CSR_ADDR_PC_LOW)
        |=> pc_q == $past(pc_q) + 9'h001)
        else $error("pc did not advance");
    pc_low_wr_a: assert property (
        PC_OP_I == CSR_PC_STEP && wr_ok && wr_eff == CSR_ADDR_PC_LOW
        |=> pc_q == {1'b0, $past(WR_DATA_I)})
        else $error("low byte write wrong");
    self_ptr_rd_a: assert property (
        RD_ADDR_I == CSR_ADDR_INDIRECT && pointer_q == CSR_ADDR_INDIRECT
        |=> RD_DATA_O == 8'h00)
        else $error("self pointer read not zero");
    self_ptr_wr_a: assert property (
        WR_EN_I && WR_ADDR_I == CSR_ADDR_INDIRECT && pointer_q == CSR_ADDR_INDIRECT
        |=> !EFF_WR_EN_O)
        else $error("self pointer write passed");
    port_a_upper_a: assert property (RD_ADDR_I == CSR_ADDR_PORT_A |=>
        RD_DATA_O[7:4] == 4'h0)
        else $error("port a upper bits set");
    latch_hold_a: assert property (!(wr_ok && wr_eff == CSR_ADDR_PORT_B) |=>
        $stable(latch_b_q))
        else $error("port b latch changed");
    dir_oe_a: assert property (DIR_LOAD_B_I |-> ##2 PORT_B_OE_O == ~$past(ACC_I, 2))
        else $error("direction drive wrong");

    call_cov_c: cover property (PC_OP_I == CSR_PC_CALL ##1 PC_OP_I == CSR_PC_CALL ##1 PC_OP_I == CSR_PC_RET);
    ind_cov_c: cover property (WR_EN_I && WR_ADDR_I == CSR_ADDR_INDIRECT && pointer_q == CSR_ADDR_PORT_B);
    halt_cov_c: cover property (HALT_I);
    flag_wr_cov_c: cover property (FLAGS_I.upd_null && wr_ok && wr_eff == CSR_ADDR_STATUS);
endmodule : csr_core

// *** csr_pin_model.sv ***
module csr_pin_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] drv_i,     // Latch from the block
    input  wire logic [W-1:0] oe_i,      // Drive enable, high drives
    input  wire logic [W-1:0] ext_en_i,  // Outside circuit drives
    input  wire logic [W-1:0] ext_val_i, // Level the outside drives
    output logic      [W-1:0] pin_o      // Resolved pin level
);
    timeunit 1ns;
    timeprecision 100ps;
    // Outside source overpowers the pad; released pins pulled up
    // resolved pin level
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_o[i] = ext_en_i[i] ? ext_val_i[i] : (oe_i[i] ? drv_i[i] : 1'b1);
        end
    end
endmodule : csr_pin_model

// *** tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import csr_pkg::*;
    typedef struct {int s; logic [11:0] v;} csr_note_s;
    logic clk, rst_n, wr_en, halt, opt_ld, dla, dlb, e_we, acc_ld;
    csr_pc_op_e pc_op;
    csr_flags_s flags;
    csr_timer_cfg_s tcfg;
    logic [8:0] pc_ld, pc;
    logic [7:0] lit, wr_d, acc, ext_rd, b_en, b_val, pin_b, rd_d, st, b_out, b_oe, acc_d;
    logic [4:0] rd_a, wr_a, e_rd, e_wr;
    logic [3:0] pin_a, a_out, a_oe;
    logic [31:0] r;
    int errors, n_compared;
    csr_note_s q[$];
    csr_note_s note;
    string nm[11] = '{"pc", "status", "rd_data", "timer_cfg", "oe_b", "out_b", "eff_rd",
                      "port_a", "acc", "eff_wr_en", "eff_wr"};
    csr_core i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PC_OP_I(pc_op), .PC_LOAD_I(pc_ld),
        .LITERAL_I(lit), .RD_ADDR_I(rd_a), .WR_ADDR_I(wr_a), .WR_EN_I(wr_en),
        .WR_DATA_I(wr_d), .FLAGS_I(flags), .HALT_I(halt), .OPTION_LOAD_I(opt_ld),
        .DIR_LOAD_A_I(dla), .DIR_LOAD_B_I(dlb), .ACC_I(acc), .EXT_RD_DATA_I(ext_rd),
        .PORT_A_PIN_I(pin_a), .PORT_B_PIN_I(pin_b), .PC_O(pc), .RD_DATA_O(rd_d),
        .EFF_RD_ADDR_O(e_rd), .EFF_WR_ADDR_O(e_wr), .EFF_WR_EN_O(e_we),
        .ACC_LOAD_O(acc_ld), .ACC_DATA_O(acc_d), .TIMER_CFG_O(tcfg), .PORT_A_OUT_O(a_out),
        .PORT_A_OE_O(a_oe), .PORT_B_OUT_O(b_out), .PORT_B_OE_O(b_oe), .STATUS_O(st));
    csr_pin_model #(.W(4)) i_pin_a (.drv_i(a_out), .oe_i(a_oe), .ext_en_i(4'h0),
        .ext_val_i(4'h0), .pin_o(pin_a));
    csr_pin_model #(.W(8)) i_pin_b (.drv_i(b_out), .oe_i(b_oe), .ext_en_i(b_en),
        .ext_val_i(b_val), .pin_o(pin_b));

    // ----------------------------------------
    // Helpers and result monitor
    // ----------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [11:0] seen(int s);
        case (s)
            0: return {3'h0, pc};
            1: return {4'h0, st};
            2: return {4'h0, rd_d};
            3: return tcfg;
            4: return {4'h0, b_oe};
            5: return {4'h0, b_out};
            6: return {7'h0, e_rd};
            7: return {4'h0, a_oe, a_out};
            8: return {3'h0, acc_ld, acc_d};
            9: return {11'h0, e_we};
            default: return {6'h0, e_we, e_wr};
        endcase
    endfunction : seen
    task automatic step();
        @(posedge clk);
        #5;
    endtask : step
    task automatic chk(input int s, input logic [11:0] v);
        q.push_back('{s, v});
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wr_a = a;
        wr_d = d;
        wr_en = 1'b1;
        step();
        wr_en = 1'b0;
    endtask : wr
    task automatic pc_do(input csr_pc_op_e op, input logic [8:0] l);
        pc_op = op;
        pc_ld = l;
        step();
    endtask : pc_do
    task automatic rst_chk();
        chk(0, 12'h1FF);
        chk(1, 12'h018);
        chk(4, 12'h000);
        chk(3, {3'b111, 9'h001});
        $display("test reset done");
    endtask : rst_chk
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    always @(negedge clk) begin
        while (q.size() > 0) begin
            note = q.pop_front();
            n_compared++;
            if (seen(note.s) !== note.v) begin
                errors++;
                $display("mismatch %s expected %h seen %h", nm[note.s], note.v, seen(note.s));
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, wr_en, halt, opt_ld, dla, dlb, b_en, b_val} = '0;
        {pc_ld, lit, wr_d, acc, ext_rd, wr_a} = '0;
        pc_op = CSR_PC_HOLD;
        flags = '0;
        rd_a = 5'h07;
        r = 32'h0b1028f5;
        errors = 0;
        n_compared = 0;
        repeat (12) step();
        rst_n = 1'b1;
        step();
        rst_chk();
        pc_do(CSR_PC_STEP, 9'h000);
        chk(0, 12'h000);
        pc_do(CSR_PC_JUMP, 9'h1A5);
        chk(0, 12'h1A5);
        pc_do(CSR_PC_CALL, 9'h142);
        chk(0, 12'h042);
        pc_do(CSR_PC_CALL, 9'h110);
        pc_do(CSR_PC_CALL, 9'h020);
        lit = r[7:0];
        pc_do(CSR_PC_RET, 9'h000);
        chk(0, 12'h011);
        chk(8, {4'h1, lit});
        pc_do(CSR_PC_RET, 9'h000);
        chk(0, 12'h043);
        pc_do(CSR_PC_RET, 9'h000);
        chk(0, 12'h043);
        pc_do(CSR_PC_JUMP, 9'h1F0);
        pc_op = CSR_PC_STEP;
        wr(CSR_ADDR_PC_LOW, 8'h7E);
        pc_op = CSR_PC_HOLD;
        chk(0, 12'h07E);
        $display("test program counter done");
        halt = 1'b1;
        step();
        halt = 1'b0;
        chk(1, 12'h010);
        wr(CSR_ADDR_STATUS, 8'h00);
        chk(1, 12'h010);
        step();
        wr(CSR_ADDR_STATUS, 8'h08);
        chk(1, 12'h010);
        step();
        flags = 6'b111_010;
        wr(CSR_ADDR_STATUS, 8'hE7);
        flags = '0;
        chk(1, 12'h0F2);
        for (int k = 0; k < 4; k++) begin
            r = lfsr(r);
            flags = {3'b111, r[2:0]};
            step();
            chk(1, {4'h0, 5'b11110, r[2:0]});
        end
        flags = '0;
        $display("test status done");
        for (int c = 0; c < 9; c++) begin
            r = lfsr(r);
            acc = {r[7:6], c[0], c[1], c == 8, c[2:0]};
            opt_ld = 1'b1;
            step();
            opt_ld = 1'b0;
            step();
            chk(3, {c[0], c[1], c == 8, (c == 8) ? 9'h001 : 9'h002 << c[2:0]});
        end
        $display("test option done");
        acc = 8'h0F;
        dlb = 1'b1;
        wr(CSR_ADDR_PORT_B, 8'h55);
        dlb = 1'b0;
        step();
        chk(5, 12'h055);
        chk(4, 12'h0F0);
        r = lfsr(r);
        b_en = 8'hF1;
        b_val = {r[7:4], 4'h0};
        rd_a = CSR_ADDR_PORT_B;
        repeat (4) step();
        chk(2, {4'h0, r[7:4], 4'hE});
        chk(5, 12'h055);
        acc = 8'hF0;
        dla = 1'b1;
        wr(CSR_ADDR_PORT_A, 8'hAB);
        dla = 1'b0;
        step();
        chk(7, 12'h0FB);
        rd_a = CSR_ADDR_PORT_A;
        repeat (4) step();
        chk(2, 12'h00B);
        $display("test ports done");
        wr(CSR_ADDR_POINTER, 8'h05);
        rd_a = CSR_ADDR_INDIRECT;
        step();
        chk(2, 12'h00B);
        ext_rd = r[15:8];
        wr(CSR_ADDR_POINTER, 8'h12);
        step();
        chk(6, 12'h012);
        chk(2, {4'h0, ext_rd});
        wr(CSR_ADDR_INDIRECT, 8'h33);
        chk(10, 12'h032);
        step();
        wr(CSR_ADDR_POINTER, 8'h00);
        step();
        chk(2, 12'h000);
        wr(CSR_ADDR_INDIRECT, 8'h33);
        chk(9, 12'h000);
        $display("test indirect done");
        rst_n = 1'b0;
        repeat (2) step();
        rst_n = 1'b1;
        step();
        rst_chk();
        step();
        step();
        report_and_stop();
    end
endmodule : tb
